// ===== logic/opcr_params.svh
// Offsets, field positions and reset values for the output pair control registers
`ifndef OPCR_PARAMS_SVH
`define OPCR_PARAMS_SVH

`define OPCR_ADDR_OUT2 8'h22
`define OPCR_ADDR_OUT3 8'h23
`define OPCR_SRC_BIT 7
`define OPCR_FMT_HI 6
`define OPCR_FMT_LO 5
`define OPCR_SETA_HI 4
`define OPCR_SETA_LO 3
`define OPCR_SETB_HI 2
`define OPCR_SETB_LO 1
`define OPCR_RST_SRC 1'h1
`define OPCR_RST_FMT 2'h1
`define OPCR_RST_SETA 2'h2
`define OPCR_RST_SETB 2'h0
`define OPCR_TAIL_A0 5'h04
`define OPCR_TAIL_A1 5'h06
`define OPCR_TAIL_A2 5'h08
`define OPCR_TAIL_HCSL3 5'h10
`define OPCR_LOAD_B1 8'h32
`define OPCR_LOAD_B2 8'h64
`define OPCR_LOAD_B3 8'hc8

`endif

// ===== logic/opcr_pkg.sv
// Types shared by the output pair control registers and the channel decoders
package opcr_pkg;
	typedef enum logic [1:0] {FMT_DISABLED, FMT_AC_DIFF, FMT_HCSL, FMT_CMOS} opcr_fmt_e;
	typedef enum logic [1:0] {PIN_OFF_TRISTATE, PIN_OFF_LOW, PIN_ON_INVERTED, PIN_ON_TRUE} opcr_pin_e;
	typedef logic [1:0] opcr_field_t;
endpackage

// ===== logic/opcr_chan_if.sv
// Settings and decoded driver controls of one output channel
`timescale 1ns/100ps
interface opcr_chan_if;
	import opcr_pkg::*;
	opcr_fmt_e format;
	opcr_field_t settingA;
	opcr_field_t settingB;
	logic driverOn;
	logic [4:0] tailCurrentMa;
	logic [7:0] loadOhms;
	logic loadTristate;
	opcr_pin_e posPin;
	opcr_pin_e negPin;
	modport regs (output format, settingA, settingB,
		input driverOn, tailCurrentMa, loadOhms, loadTristate, posPin, negPin);
	modport dec (input format, settingA, settingB,
		output driverOn, tailCurrentMa, loadOhms, loadTristate, posPin, negPin);
endinterface

// ===== logic/opcr_chan_decode.sv
// Registered decode of one channel's format and drive settings
`timescale 1ns/100ps
`include "opcr_params.svh"
module opcr_chan_decode
	import opcr_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	opcr_chan_if.dec chan
);
	// Same code space serves pin states in CMOS format
	function automatic opcr_pin_e pinState(input opcr_field_t code);
		pinState = opcr_pin_e'(code);
	endfunction

	// Outputs registered so the analog controls change glitch free
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			chan.driverOn <= 1'b0;
			chan.tailCurrentMa <= 5'h00;
			chan.loadOhms <= 8'h00;
			chan.loadTristate <= 1'b1;
			chan.posPin <= PIN_OFF_TRISTATE;
			chan.negPin <= PIN_OFF_TRISTATE;
		end
		else
		begin
			chan.driverOn <= (chan.format != FMT_DISABLED);
			chan.posPin <= PIN_OFF_TRISTATE;
			chan.negPin <= PIN_OFF_TRISTATE;
			chan.tailCurrentMa <= 5'h00;
			chan.loadOhms <= 8'h00;
			chan.loadTristate <= 1'b1;
			case (chan.format)
				FMT_AC_DIFF, FMT_HCSL:
				begin
					// Tail current, code 3 doubles only in HCSL
					case (chan.settingA)
						2'h0: chan.tailCurrentMa <= `OPCR_TAIL_A0;
						2'h1: chan.tailCurrentMa <= `OPCR_TAIL_A1;
						2'h2: chan.tailCurrentMa <= `OPCR_TAIL_A2;
						default: chan.tailCurrentMa <= (chan.format == FMT_HCSL) ?
							`OPCR_TAIL_HCSL3 : `OPCR_TAIL_A2;
					endcase
					// Load resistor only meaningful in HCSL
					if (chan.format == FMT_HCSL)
					begin
						chan.loadTristate <= (chan.settingB == 2'h0);
						case (chan.settingB)
							2'h1: chan.loadOhms <= `OPCR_LOAD_B1;
							2'h2: chan.loadOhms <= `OPCR_LOAD_B2;
							2'h3: chan.loadOhms <= `OPCR_LOAD_B3;
							default: chan.loadOhms <= 8'h00;
						endcase
					end
				end
				FMT_CMOS:
				begin
					chan.posPin <= pinState(chan.settingA);
					chan.negPin <= pinState(chan.settingB);
				end
				default:
				begin
					chan.driverOn <= 1'b0;
				end
			endcase
		end
	end
endmodule

// ===== logic/opcr_regs.sv
// Output pair control registers for channels 2 and 3 with driver decode
`timescale 1ns/100ps
`include "opcr_params.svh"
module opcr_regs
	import opcr_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	input wire logic eepromLoad,
	input wire logic [7:0] eepromOut2Byte,
	input wire logic [7:0] eepromOut3Byte,
	output logic [7:0] eepromOut2Image,
	output logic [7:0] eepromOut3Image,
	output logic pair_source_select,
	output logic [1:0] chanDriverOn,
	output logic [9:0] chanTailCurrentMa,
	output logic [15:0] chanLoadOhms,
	output logic [1:0] chanLoadTristate,
	output logic [3:0] chanPosPin,
	output logic [3:0] chanNegPin
);
	logic source_ff;
	opcr_fmt_e format_ff [2];
	opcr_field_t settingA_ff [2];
	opcr_field_t settingB_ff [2];
	logic [7:0] imageByte [2];

	// Reserved bits are not stored anywhere, so they read as zero
	function automatic logic [7:0] packReg(input logic src, input opcr_fmt_e fmt,
		input opcr_field_t a, input opcr_field_t b);
		packReg = {src, fmt, a, b, 1'b0};
	endfunction

	// Source select lives only in output-2; bus write wins over EEPROM load
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			source_ff <= `OPCR_RST_SRC;
		else if (regWrEn && regAddr == `OPCR_ADDR_OUT2)
			source_ff <= regWrData[`OPCR_SRC_BIT];
		else if (eepromLoad)
			source_ff <= eepromOut2Byte[`OPCR_SRC_BIT];
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : gChan
			opcr_chan_if chanBus ();
			logic hit;
			logic [7:0] loadByte;
			assign hit = regWrEn && (regAddr == ((ch == 0) ? `OPCR_ADDR_OUT2 : `OPCR_ADDR_OUT3));
			assign loadByte = (ch == 0) ? eepromOut2Byte : eepromOut3Byte;

			// Per-channel fields; only bits 6:1 are kept
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
				begin
					format_ff[ch] <= opcr_fmt_e'(`OPCR_RST_FMT);
					settingA_ff[ch] <= `OPCR_RST_SETA;
					settingB_ff[ch] <= `OPCR_RST_SETB;
				end
				else if (hit)
				begin
					format_ff[ch] <= opcr_fmt_e'(regWrData[`OPCR_FMT_HI:`OPCR_FMT_LO]);
					settingA_ff[ch] <= regWrData[`OPCR_SETA_HI:`OPCR_SETA_LO];
					settingB_ff[ch] <= regWrData[`OPCR_SETB_HI:`OPCR_SETB_LO];
				end
				else if (eepromLoad)
				begin
					format_ff[ch] <= opcr_fmt_e'(loadByte[`OPCR_FMT_HI:`OPCR_FMT_LO]);
					settingA_ff[ch] <= loadByte[`OPCR_SETA_HI:`OPCR_SETA_LO];
					settingB_ff[ch] <= loadByte[`OPCR_SETB_HI:`OPCR_SETB_LO];
				end
			end

			// Feed the decoder and collect its controls
			assign chanBus.format = format_ff[ch];
			assign chanBus.settingA = settingA_ff[ch];
			assign chanBus.settingB = settingB_ff[ch];
			assign chanDriverOn[ch] = chanBus.driverOn;
			assign chanTailCurrentMa[ch*5 +: 5] = chanBus.tailCurrentMa;
			assign chanLoadOhms[ch*8 +: 8] = chanBus.loadOhms;
			assign chanLoadTristate[ch] = chanBus.loadTristate;
			assign chanPosPin[ch*2 +: 2] = chanBus.posPin;
			assign chanNegPin[ch*2 +: 2] = chanBus.negPin;

			// Output-3 bit 7 is reserved, so only channel 2 carries the source
			assign imageByte[ch] = packReg((ch == 0) ? source_ff : 1'b0,
				format_ff[ch], settingA_ff[ch], settingB_ff[ch]);

			opcr_chan_decode uDecode (
				.clk(clk),
				.reset(reset),
				.chan(chanBus.dec)
			);
		end
	endgenerate

	// Source select drives the pair mux directly
	assign pair_source_select = source_ff;
	// EEPROM image excludes reserved bits
	assign eepromOut2Image = imageByte[0];
	assign eepromOut3Image = imageByte[1];

	// Registered read; unmapped offsets read zero
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			regRdData <= 8'h00;
		else if (regRdEn)
		begin
			if (regAddr == `OPCR_ADDR_OUT2)
				regRdData <= imageByte[0];
			else if (regAddr == `OPCR_ADDR_OUT3)
				regRdData <= imageByte[1];
			else
				regRdData <= 8'h00;
		end
	end
endmodule

// ===== tb/opcr_regs_sva.sv
// Port checks for the output pair control registers
`timescale 1ns/100ps
module opcr_regs_sva
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic eepromLoad,
	input wire logic [7:0] eepromOut2Image,
	input wire logic [7:0] eepromOut3Image,
	input wire logic pair_source_select,
	input wire logic [1:0] chanDriverOn,
	input wire logic [9:0] chanTailCurrentMa,
	input wire logic [15:0] chanLoadOhms,
	input wire logic [3:0] chanPosPin,
	input wire logic [3:0] chanNegPin
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (reset);
	// Quiet cycle keeps a load or second write from masking the decode
	wire wr2 = regWrEn && regAddr == 8'h22;
	wire wr3 = regWrEn && regAddr == 8'h23;
	wire quiet = !regWrEn && !eepromLoad;
	// Decoded outputs land two edges after the write
	property p_src; wr2 |=> pair_source_select == $past(regWrData[7]); endproperty
	a_src: assert property (p_src) else $error("source");
	property p_off2; wr2 && regWrData[6:5] == 2'h0 ##1 quiet |=> !chanDriverOn[0]; endproperty
	a_off2: assert property (p_off2) else $error("ch2 on");
	property p_on3; wr3 && regWrData[6:5] != 2'h0 ##1 quiet |=> chanDriverOn[1]; endproperty
	a_on3: assert property (p_on3) else $error("ch3 off");
	property p_tail; wr3 && regWrData[6:3] == 4'hb ##1 quiet |=>
		chanTailCurrentMa[9:5] == 5'h10; endproperty
	a_tail: assert property (p_tail) else $error("tail");
	property p_cmos; wr2 && regWrData[6:5] == 2'h3 ##1 quiet |=>
		{chanPosPin[1:0], chanNegPin[1:0]} == $past(regWrData[4:1], 2); endproperty
	a_cmos: assert property (p_cmos) else $error("pins");
	property p_load; wr2 && regWrData[6:5] == 2'h2 && regWrData[2:1] == 2'h1 ##1 quiet |=>
		chanLoadOhms[7:0] == 8'h32; endproperty
	a_load: assert property (p_load) else $error("load");
	property p_rsv; regWrEn |=> !eepromOut2Image[0] && !eepromOut3Image[7] &&
		!eepromOut3Image[0]; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved");
	property p_img; wr3 && !eepromLoad |=> eepromOut3Image[6:1] == $past(regWrData[6:1]);
		endproperty
	a_img: assert property (p_img) else $error("image");
	// Main scenarios reached
	c_cmos: cover property (wr2 && regWrData[6:5] == 2'h3);
	c_race: cover property (wr2 && eepromLoad);
	c_w3: cover property (wr3 ##1 quiet);
endmodule
bind opcr_regs opcr_regs_sva u_sva (
	.clk(clk),
	.reset(reset),
	.regAddr(regAddr),
	.regWrEn(regWrEn),
	.regWrData(regWrData),
	.eepromLoad(eepromLoad),
	.eepromOut2Image(eepromOut2Image),
	.eepromOut3Image(eepromOut3Image),
	.pair_source_select(pair_source_select),
	.chanDriverOn(chanDriverOn),
	.chanTailCurrentMa(chanTailCurrentMa),
	.chanLoadOhms(chanLoadOhms),
	.chanPosPin(chanPosPin),
	.chanNegPin(chanNegPin)
);

// ===== tb/test_output_pair_control_regs.sv
// Bench for the output pair control registers
`timescale 1ns/100ps
module test_output_pair_control_regs;
	logic clk = 0, reset = 1, regWrEn = 0, regRdEn = 0, eepromLoad = 0;
	logic [7:0] regAddr = 0, regWrData = 0, eepromOut2Byte = 0, eepromOut3Byte = 0;
	logic [7:0] regRdData, eepromOut2Image, eepromOut3Image, a, d, m2 = 8'hb0, m3 = 8'h30;
	logic [15:0] chanLoadOhms, hand[5] = '{16'h2242, 16'h2358, 16'h2200, 16'h2276, 16'h2301};
	logic [9:0] chanTailCurrentMa;
	logic [3:0] chanPosPin, chanNegPin;
	logic [1:0] chanDriverOn, chanLoadTristate;
	logic pair_source_select;
	logic [31:0] seed = 98;
	int miscompares = 0, nCompared = 0, cyc = 0;
	opcr_regs u_dut (
		.clk(clk),
		.reset(reset),
		.regAddr(regAddr),
		.regWrEn(regWrEn),
		.regWrData(regWrData),
		.regRdEn(regRdEn),
		.regRdData(regRdData),
		.eepromLoad(eepromLoad),
		.eepromOut2Byte(eepromOut2Byte),
		.eepromOut3Byte(eepromOut3Byte),
		.eepromOut2Image(eepromOut2Image),
		.eepromOut3Image(eepromOut3Image),
		.pair_source_select(pair_source_select),
		.chanDriverOn(chanDriverOn),
		.chanTailCurrentMa(chanTailCurrentMa),
		.chanLoadOhms(chanLoadOhms),
		.chanLoadTristate(chanLoadTristate),
		.chanPosPin(chanPosPin),
		.chanNegPin(chanNegPin)
	);
	// Clock, and a ceiling that cuts a hang short
	always #20 clk = ~clk;
	always @(posedge clk)
		if (++cyc > 1000)
			conclude(1);
	// Xorshift stream, repeatable from the fixed seed
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Tail current in mA, zero when not differential
	function automatic logic [4:0] tailx(logic [7:0] v);
		if (v[6:5] == 2'h0 || v[6:5] == 2'h3)
			return 5'h00;
		return v[4:3] == 2'h3 ? (v[6:5] == 2'h2 ? 5'h10 : 5'h08) : 5'h04 + {2'h0, v[4:3], 1'h0};
	endfunction
	// Load in ohms, zero outside HCSL
	function automatic logic [7:0] loadx(logic [7:0] v);
		if (v[6:5] != 2'h2)
			return 8'h00;
		return v[2:1] == 2'h1 ? 8'h32 : v[2:1] == 2'h2 ? 8'h64 : v[2:1] == 2'h3 ? 8'hc8 : 8'h00;
	endfunction
	// Load is tristated unless HCSL with a nonzero load code
	function automatic logic trix(logic [7:0] v);
		return v[6:5] != 2'h2 || v[2:1] == 2'h0;
	endfunction
	// CMOS pin state: setting A for the positive pin, B for the negative
	function automatic logic [1:0] pinx(logic [7:0] v, logic neg);
		if (v[6:5] != 2'h3)
			return 2'h0;
		return neg ? v[2:1] : v[4:3];
	endfunction
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Write, then read the same offset back; reserved bits must come back zero
	task automatic xfer(logic [7:0] ad, logic [7:0] dd);
		regAddr = ad;
		regWrData = dd;
		regWrEn = 1;
		@(posedge clk);
		#1 regWrEn = 0;
		eepromLoad = 0;
		regRdEn = 1;
		m2 = ad == 8'h22 ? {dd[7:1], 1'h0} : m2;
		m3 = ad == 8'h23 ? {1'h0, dd[6:1], 1'h0} : m3;
		@(posedge clk);
		#1 regRdEn = 0;
		chk(regRdData, ad == 8'h22 ? m2 : ad == 8'h23 ? m3 : 8'h00);
	endtask
	task automatic conclude(int hung);
		miscompares += hung;
		$display("compared %0d, mismatches %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Reset values, corners among random writes, then a write racing a load
	initial
	begin
		repeat (12) @(posedge clk);
		#1 reset = 0;
		xfer(8'h24, 8'hff);
		chk(pair_source_select, 1'h1);
		chk({eepromOut2Image, eepromOut3Image}, 16'hb030);
		chk(chanLoadTristate, 2'h3);
		chk(chanTailCurrentMa, 10'h108);
		chk(chanDriverOn, 2'h3);
		$display("reset test done");
		for (int i = 0; i < 60; i++)
		begin
			a = 8'h21 + rnd() % 8'h3;
			d = rnd();
			if (i < 5)
				{a, d} = hand[i];
			// Software keeps reserved bits at zero
			d = d & ((a == 8'h22) ? 8'hfe : 8'h7e);
			xfer(a, d);
			chk(chanDriverOn, {m3[6:5] != 2'h0, m2[6:5] != 2'h0});
			chk(chanTailCurrentMa, {tailx(m3), tailx(m2)});
			chk(pair_source_select, m2[7]);
			chk(chanLoadOhms, {loadx(m3), loadx(m2)});
			chk(chanLoadTristate, {trix(m3), trix(m2)});
			chk({chanPosPin, chanNegPin}, {pinx(m3, 0), pinx(m2, 0), pinx(m3, 1), pinx(m2, 1)});
			chk({eepromOut2Image, eepromOut3Image}, {m2, m3});
		end
		$display("register test done");
		eepromOut3Byte = 8'hff;
		eepromLoad = 1;
		xfer(8'h22, 8'hc6);
		chk(eepromOut3Image, 8'h7e);
		chk(chanLoadOhms[7:0], 8'hc8);
		$display("eeprom test done");
		conclude(0);
	end
endmodule
